// >>> bench/tb.sv
`timescale 1ns/1ps
`include "tcm_defs.svh"

module tb;
   import tcm_pkg::*;

   logic                  clock;
   logic                  rst_b;
   logic                  timer_clock_gate;
   logic                  run_bit;
   logic [2:0]            operating_mode_field;
   logic [1:0]            source_clock_select;
   logic                  edge_or_level_select;
   logic                  trigger_stop_enable;
   logic                  overflow_irq_enable;
   logic                  double_buffer_enable;
   logic                  auto_capture_enable;
   logic                  compare_a_low_wr;
   logic                  compare_a_high_wr;
   logic [7:0]            compare_wdata;
   logic                  capture_b_low_rd;
   logic                  timer_input_pin;
   logic                  timer_irq;
   logic                  timer_running;
   tcm_mode_type          timer_mode_reg;
   logic [`TCM_CNT_W-1:0] count_value;
   logic [`TCM_CNT_W-1:0] compare_reg_a;
   logic [7:0]            capture_b_low;
   logic [7:0]            capture_b_high;
   int                    miscompares;
   int                    n_tests;

   tcm_timer u_dut (.clock(clock), .rst_b(rst_b), .timer_input_pin(timer_input_pin),
      .timer_clock_gate(timer_clock_gate), .run_bit(run_bit), .operating_mode_field(operating_mode_field),
      .source_clock_select(source_clock_select), .edge_or_level_select(edge_or_level_select),
      .trigger_stop_enable(trigger_stop_enable), .overflow_irq_enable(overflow_irq_enable),
      .double_buffer_enable(double_buffer_enable), .auto_capture_enable(auto_capture_enable),
      .compare_a_low_wr(compare_a_low_wr), .compare_a_high_wr(compare_a_high_wr),
      .compare_wdata(compare_wdata), .capture_b_low_rd(capture_b_low_rd), .timer_irq(timer_irq),
      .timer_running(timer_running), .timer_mode_reg(timer_mode_reg), .count_value(count_value),
      .compare_reg_a(compare_reg_a), .capture_b_low(capture_b_low), .capture_b_high(capture_b_high));

   tcm_pulse_src u_src (.clock(clock), .timer_input_pin(timer_input_pin));

   initial clock = 1'b0;
   always #50 clock = ~clock;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // outputs are looked at just after the edge, once the registers have settled
   task automatic check16(input logic [15:0] act, input logic [15:0] exp);
      #1;
      n_tests++;
      if (act !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, act, exp);
      end
   endtask

   task automatic check1(input logic act, input logic exp);
      check16({15'h0000, act}, {15'h0000, exp});
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask

   // count only settles after the pin pipeline, so poll with a bound
   task automatic wait_cnt(input logic [15:0] exp, input int lim);
      int i;
      i = 0;
      #1;
      while (count_value !== exp && i < lim)
      begin
         @(posedge clock);
         #1;
         i++;
      end
      check16(count_value, exp);
   endtask

   task automatic wait_irq(input int lim);
      int i;
      i = 0;
      #1;
      while (timer_irq !== 1'b1 && i < lim)
      begin
         @(posedge clock);
         #1;
         i++;
      end
      check1(timer_irq, 1'b1);
   endtask

   task automatic wr_cmp(input logic [15:0] v);
      @(posedge clock);
      compare_a_low_wr <= 1'b1;
      compare_wdata    <= v[7:0];
      @(posedge clock);
      compare_a_low_wr  <= 1'b0;
      compare_a_high_wr <= 1'b1;
      compare_wdata     <= v[15:8];
      @(posedge clock);
      compare_a_high_wr <= 1'b0;
   endtask

   task automatic start(input logic [2:0] m, input logic [1:0] s, input logic es, input logic se);
      int i;
      i = 0;
      cyc(2);
      operating_mode_field <= m;
      source_clock_select  <= s;
      edge_or_level_select <= es;
      trigger_stop_enable  <= se;
      run_bit              <= 1'b1;
      @(posedge clock);
      while (timer_running !== 1'b1 && i < 8)
      begin
         @(posedge clock);
         i++;
      end
      check1(timer_running, 1'b1);
   endtask

   task automatic stop();
      @(posedge clock);
      run_bit <= 1'b0;
      cyc(3);
      check16(count_value, 16'h0000);
      check1(timer_running, 1'b0);
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset();
      check1(timer_irq, 1'b0);
      check16(count_value, `TCM_CNT_RESET);
      check16(compare_reg_a, `TCM_CMP_RESET);
      @(posedge clock);
      run_bit <= 1'b1;
      cyc(6);
      check1(timer_running, 1'b0);
      @(posedge clock);
      run_bit          <= 1'b0;
      timer_clock_gate <= 1'b1;
      cyc(2);
   endtask

   task automatic t_event();
      for (int es = 0; es < 2; es++)
      begin
         u_src.set_level(es[0]);
         wr_cmp(16'h0002);
         start(`TCM_MODE_EVENT, 2'h3, es[0], 1'b0);
         u_src.pulse();
         wait_cnt(16'h0001, 20);
         @(posedge clock);
         auto_capture_enable <= 1'b1;
         capture_b_low_rd    <= 1'b1;
         @(posedge clock);
         capture_b_low_rd <= 1'b0;
         cyc(2);
         check16({capture_b_high, capture_b_low}, 16'h0001);
         @(posedge clock);
         operating_mode_field <= `TCM_MODE_WINDOW;
         overflow_irq_enable  <= 1'b1;
         cyc(2);
         check16({13'h0000, timer_mode_reg.op_mode}, {13'h0000, `TCM_MODE_EVENT});
         check1(timer_mode_reg.ovf_en, 1'b0);
         @(posedge clock);
         overflow_irq_enable <= 1'b0;
         u_src.pulse();
         wait_cnt(16'h0002, 20);
         // the one-cycle irq pulse comes while the pulse is still being held
         fork
            u_src.pulse();
            wait_irq(20);
         join
         wait_cnt(16'h0000, 4);
         stop();
      end
   endtask

   task automatic t_ext();
      // compare well above the counts reached, so no match clears the count here
      wr_cmp(16'h0040);
      for (int se = 0; se < 2; se++)
      begin
         u_src.set_level(se[0]);
         start(`TCM_MODE_EXT_TRIG, 2'h3, se[0], se[0]);
         cyc(12);
         check16(count_value, 16'h0000);
         u_src.set_level(!se[0]);
         wait_cnt(16'h0003, 30);
         u_src.set_level(se[0]);
         if (se == 1)
         begin
            wait_cnt(16'h0000, 12);
            cyc(8);
            check16(count_value, 16'h0000);
            u_src.set_level(!se[0]);
            wait_cnt(16'h0003, 30);
         end
         else
         begin
            cyc(8);
            check1(count_value > 16'h0003, 1'b1);
         end
         stop();
      end
   endtask

   task automatic t_window();
      logic [15:0] held;
      for (int es = 0; es < 2; es++)
      begin
         u_src.set_level(es[0]);
         start(`TCM_MODE_WINDOW, 2'h2, es[0], 1'b0);
         cyc(16);
         check16(count_value, 16'h0000);
         u_src.set_level(!es[0]);
         wait_cnt(16'h0002, 30);
         u_src.set_level(es[0]);
         cyc(4);
         #1;
         held = count_value;
         cyc(16);
         check16(count_value, held);
         stop();
      end
   endtask

   // while running, a double-buffered value only applies from the next match
   task automatic t_dbuf();
      wr_cmp(16'h1234);
      cyc(1);
      check16(compare_reg_a, 16'h1234);
      @(posedge clock);
      double_buffer_enable <= 1'b1;
      u_src.set_level(1'b0);
      wr_cmp(16'h0005);
      start(`TCM_MODE_EVENT, 2'h3, 1'b0, 1'b0);
      wr_cmp(16'h0001);
      cyc(1);
      check16(compare_reg_a, 16'h0001);
      repeat (2) u_src.pulse();
      wait_cnt(16'h0002, 20);
      repeat (4) u_src.pulse();
      wait_cnt(16'h0000, 20);
      u_src.pulse();
      wait_cnt(16'h0001, 20);
      u_src.pulse();
      wait_cnt(16'h0000, 20);
      stop();
   endtask

   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial
   begin
      miscompares          = 0;
      n_tests              = 0;
      rst_b                = 1'b0;
      timer_clock_gate     = 1'b0;
      run_bit              = 1'b0;
      operating_mode_field = 3'h0;
      source_clock_select  = 2'h0;
      edge_or_level_select = 1'b0;
      trigger_stop_enable  = 1'b0;
      overflow_irq_enable  = 1'b0;
      double_buffer_enable = 1'b0;
      auto_capture_enable  = 1'b0;
      compare_a_low_wr     = 1'b0;
      compare_a_high_wr    = 1'b0;
      compare_wdata        = 8'h00;
      capture_b_low_rd     = 1'b0;
      cyc(4);
      rst_b <= 1'b1;
      cyc(1);
      t_reset();
      t_event();
      t_ext();
      t_window();
      t_dbuf();
      give_verdict();
   end

   // all scenarios take a few hundred cycles; the 20000-cycle limit is ample margin
   initial
   begin
      #(100 * 20000);
      miscompares++;
      give_verdict();
   end

endmodule // tb

// >>> bench/tcm_pulse_src.sv
`timescale 1ns/1ps

// ----------------------------------------
// external pulse source on the timer input pin
// ----------------------------------------
module tcm_pulse_src
#(
   parameter int HOLD_CYC = 4
)
(
   input  wire logic clock,
   output logic      timer_input_pin
);

   // the pin is only ever driven from here, the block treats it as input
   initial timer_input_pin = 1'b0;

   // every level is held HOLD_CYC + 1 cycles or more, well above the two-cycle minimum
   // so the shortest window level lasts only just over one DIV4 source clock period
   task automatic set_level(input logic v);
      @(posedge clock);
      timer_input_pin <= v;
      repeat (HOLD_CYC) @(posedge clock);
   endtask

   task automatic pulse();
      set_level(!timer_input_pin);
      set_level(!timer_input_pin);
   endtask

endmodule // tcm_pulse_src

// >>> rtl/tcm_defs.svh
`ifndef TCM_DEFS_SVH
`define TCM_DEFS_SVH

// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define TCM_CNT_W        16
`define TCM_PRESC_W      10
`define TCM_CNT_RESET    16'h0000
`define TCM_CMP_RESET    16'hffff
`define TCM_BYTE_RESET   8'h00

// ----------------------------------------
// operating mode codes
// ----------------------------------------
`define TCM_MODE_EXT_TRIG 3'h4
`define TCM_MODE_EVENT    3'h2
`define TCM_MODE_WINDOW   3'h5

// ----------------------------------------
// source clock select: prescaler bits per tick
// ----------------------------------------
`define TCM_SEL_DIV1024   2'h0
`define TCM_SEL_DIV64     2'h1
`define TCM_SEL_DIV4      2'h2
`define TCM_SEL_DIV2      2'h3
`define TCM_MASK_DIV1024  10'h3ff
`define TCM_MASK_DIV64    10'h03f
`define TCM_MASK_DIV4     10'h003
`define TCM_MASK_DIV2     10'h001

`endif

// >>> rtl/tcm_input_sync.sv
`timescale 1ns/1ps

module tcm_input_sync
#(
   parameter int SYNC_STAGES = 2
)
(
   input  wire logic clock,
   input  wire logic rst_b,
   input  wire logic timer_input_pin,
   tcm_pin_if.src    pin_bus
);
   import tcm_pkg::*;

   typedef struct packed {
      logic [SYNC_STAGES-1:0] sync;
      logic                   level;
      logic                   rise;
      logic                   fall;
   } tcm_sync_state_type;

   tcm_sync_state_type st_r;
   tcm_sync_state_type st_nxt;

   initial
   begin
      if (SYNC_STAGES < 2)
         $error("tcm_input_sync: SYNC_STAGES must be at least 2");
   end

   // ----------------------------------------
   // synchroniser and edge detect
   // ----------------------------------------
   // edges are taken from the last stage only, never from the first
   always_comb
   begin
      st_nxt       = st_r;
      st_nxt.sync  = {st_r.sync[SYNC_STAGES-2:0], timer_input_pin};       // [R21]
      st_nxt.level = st_r.sync[SYNC_STAGES-1];
      st_nxt.rise  = st_r.sync[SYNC_STAGES-1] & ~st_r.level;
      st_nxt.fall  = ~st_r.sync[SYNC_STAGES-1] & st_r.level;
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign pin_bus.level = st_r.level;
   assign pin_bus.rise  = st_r.rise;
   assign pin_bus.fall  = st_r.fall;

endmodule // tcm_input_sync

// >>> rtl/tcm_pin_if.sv
`timescale 1ns/1ps

interface tcm_pin_if;
   logic level;
   logic rise;
   logic fall;

   modport src
   (
      output level,
      output rise,
      output fall
   );

   modport dst
   (
      input level,
      input rise,
      input fall
   );
endinterface

// >>> rtl/tcm_pkg.sv
`include "tcm_defs.svh"

package tcm_pkg;

   typedef enum logic [1:0] {
      TCM_WAIT  = 2'b01,
      TCM_COUNT = 2'b10
   } tcm_trig_state_type;

   typedef struct packed {
      logic [2:0] op_mode;
      logic [1:0] clk_sel;
      logic       edge_sel;
      logic       stop_en;
      logic       ovf_en;
   } tcm_mode_type;

   typedef struct packed {
      tcm_mode_type              mode;
      logic                      run;
      tcm_trig_state_type        trig;
      logic [`TCM_PRESC_W-1:0]   presc;
      logic [`TCM_CNT_W-1:0]     count;
      logic [7:0]                temp;
      logic [`TCM_CNT_W-1:0]     dbuf;
      logic [`TCM_CNT_W-1:0]     cmp;
      logic                      pending;
      logic [`TCM_CNT_W-1:0]     cap;
      logic                      irq;
   } tcm_state_type;

endpackage

// >>> rtl/tcm_timer.sv
`timescale 1ns/1ps
`include "tcm_defs.svh"

// Function
// R1: operating mode 100 plus run bit gives externally triggered timer mode
// R2: trigger edge select: 0 rising, 1 falling
// R3: while running, mode settings and overflow enable writes are ignored
// R4: triggered mode idles until trigger edge, then counts source clock ticks
// R5: compare A match raises interrupt, clears counter, counting continues
// R6: stop enable 1: opposite edge stops and clears; next trigger restarts
// R7: stop enable 0: edges ignored from trigger until next match
// R8: clearing run bit stops and clears the counter
// R9: operating mode 010 gives event counting, one count per selected edge
// R10: event counting edge select: 0 rising, 1 falling
// R11: event source at most half the clock, each level two cycles or more
// R12: operating mode 101 gives window mode counting selected source clock
// R13: window level select: 0 counts while high, 1 while low
// R14: window counts source ticks gated by active level; clears on match
// R15: window input should toggle well below the source clock rate
// R16: software configures the pin as input before starting
// R17: compare low byte goes to holding buffer; high byte commits both
// R18: double buffered compare takes effect at match; reads give last written
// R19: auto capture: low byte read latches live count and high byte together
// R20: clock gate 0 (reset value) keeps the timer from operating
// R21: 16-bit counter; input pin synchronised before edge or level detection
// R22: counter wraps from ffff to zero without a match and keeps counting

module tcm_timer
#(
   parameter int SYNC_STAGES = 2
)
(
   input  wire logic                  clock,
   input  wire logic                  rst_b,
   input  wire logic                  timer_input_pin,
   input  wire logic                  timer_clock_gate,
   input  wire logic                  run_bit,
   input  wire logic [2:0]            operating_mode_field,
   input  wire logic [1:0]            source_clock_select,
   input  wire logic                  edge_or_level_select,
   input  wire logic                  trigger_stop_enable,
   input  wire logic                  overflow_irq_enable,
   input  wire logic                  double_buffer_enable,
   input  wire logic                  auto_capture_enable,
   input  wire logic                  compare_a_low_wr,
   input  wire logic                  compare_a_high_wr,
   input  wire logic [7:0]            compare_wdata,
   input  wire logic                  capture_b_low_rd,
   output logic                       timer_irq,
   output logic                       timer_running,
   output tcm_pkg::tcm_mode_type      timer_mode_reg,
   output logic [`TCM_CNT_W-1:0]      count_value,
   output logic [`TCM_CNT_W-1:0]      compare_reg_a,
   output logic [7:0]                 capture_b_low,
   output logic [7:0]                 capture_b_high
);
   import tcm_pkg::*;

   tcm_state_type           st_r;
   tcm_state_type           st_nxt;
   tcm_pin_if               pin_bus ();
   logic [`TCM_PRESC_W-1:0] tick_mask;
   logic                    tick;
   logic                    sel_edge;
   logic                    opp_edge;
   logic                    win_active;
   logic                    inc;
   logic                    match;
   logic                    is_ext;
   logic                    is_event;
   logic                    is_win;
   logic [`TCM_CNT_W-1:0]   commit_val;

   // ----------------------------------------
   // input pin conditioning
   // ----------------------------------------
   tcm_input_sync #(.SYNC_STAGES(SYNC_STAGES)) u_sync
   (
      .clock           (clock),
      .rst_b           (rst_b),
      .timer_input_pin (timer_input_pin),
      .pin_bus         (pin_bus)
   );

   // ----------------------------------------
   // decode of mode, source clock and pin
   // ----------------------------------------
   always_comb
   begin
      case (st_r.mode.clk_sel)
         `TCM_SEL_DIV1024: tick_mask = `TCM_MASK_DIV1024;
         `TCM_SEL_DIV64:   tick_mask = `TCM_MASK_DIV64;
         `TCM_SEL_DIV4:    tick_mask = `TCM_MASK_DIV4;
         `TCM_SEL_DIV2:    tick_mask = `TCM_MASK_DIV2;
         default:          tick_mask = `TCM_MASK_DIV1024;
      endcase
   end

   assign tick       = &(st_r.presc | ~tick_mask);
   assign is_ext     = (st_r.mode.op_mode == `TCM_MODE_EXT_TRIG);                    // [R1]
   assign is_event   = (st_r.mode.op_mode == `TCM_MODE_EVENT);                       // [R9]
   assign is_win     = (st_r.mode.op_mode == `TCM_MODE_WINDOW);                      // [R12]
   assign sel_edge   = st_r.mode.edge_sel ? pin_bus.fall : pin_bus.rise;             // [R2] [R10]
   assign opp_edge   = st_r.mode.edge_sel ? pin_bus.rise : pin_bus.fall;
   assign win_active = pin_bus.level ^ st_r.mode.edge_sel;                           // [R13]
   assign commit_val = {compare_wdata, st_r.temp};

   // one increment request per cycle; other mode codes are not served here
   always_comb
   begin
      inc = 1'b0;
      if (st_r.run)
      begin
         if (is_ext)
            inc = (st_r.trig == TCM_COUNT) && tick &&
                  !(st_r.mode.stop_en && opp_edge);                                 // [R4]
         else if (is_event)
            inc = sel_edge;                                                          // [R9]
         else if (is_win)
            inc = tick && win_active;                                                // [R14]
      end
   end

   assign match = inc && (st_r.count == st_r.cmp);                                   // [R5]

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      st_nxt     = st_r;
      st_nxt.irq = match;                                                            // [R5]
      st_nxt.run = run_bit & timer_clock_gate;                                       // [R20]

      // settings are only taken while stopped
      if (!st_r.run)
      begin
         st_nxt.mode.op_mode  = operating_mode_field;                                // [R3]
         st_nxt.mode.clk_sel  = source_clock_select;
         st_nxt.mode.edge_sel = edge_or_level_select;
         st_nxt.mode.stop_en  = trigger_stop_enable;
         st_nxt.mode.ovf_en   = overflow_irq_enable;
      end

      // prescaler restarts with each start so the first tick is deterministic
      if (st_r.run)
         st_nxt.presc = st_r.presc + 1'b1;
      else
         st_nxt.presc = '0;

      // counter: cleared on the edge that running drops, so a stopped timer never shows a stale count
      if (!st_nxt.run)
      begin
         st_nxt.count = `TCM_CNT_RESET;                                              // [R8]
         st_nxt.trig  = TCM_WAIT;
      end
      else if (match)
         st_nxt.count = `TCM_CNT_RESET;                                              // [R5] [R14]
      else if (inc)
         st_nxt.count = st_r.count + 1'b1;                                           // [R21] [R22]

      // trigger sequencing
      if (st_r.run && st_nxt.run && is_ext)
      begin
         case (st_r.trig)
            TCM_WAIT:
            begin
               if (sel_edge)
                  st_nxt.trig = TCM_COUNT;                                           // [R4]
            end
            TCM_COUNT:
            begin
               // with stop disabled no edge is looked at while counting
               if (st_r.mode.stop_en && opp_edge)
               begin
                  st_nxt.trig  = TCM_WAIT;                                           // [R6]
                  st_nxt.count = `TCM_CNT_RESET;
               end
            end                                                                      // [R7]
            default:
               st_nxt.trig = TCM_WAIT;
         endcase
      end

      // compare register A: holding buffer and double buffer
      if (compare_a_low_wr)
         st_nxt.temp = compare_wdata;                                                // [R17]
      if (match && st_r.pending)
      begin
         st_nxt.cmp     = st_r.dbuf;                                                 // [R18]
         st_nxt.pending = 1'b0;
      end
      else if (!st_r.run && st_r.pending)
      begin
         st_nxt.cmp     = st_r.dbuf;
         st_nxt.pending = 1'b0;
      end
      if (compare_a_high_wr)
      begin
         st_nxt.dbuf = commit_val;                                                   // [R17]
         if (double_buffer_enable && st_r.run)
            st_nxt.pending = 1'b1;                                                   // [R18]
         else
         begin
            st_nxt.cmp     = commit_val;
            st_nxt.pending = 1'b0;
         end
      end

      // auto capture: a stopped timer reads back zero in both bytes
      if (capture_b_low_rd && auto_capture_enable)
      begin
         if (st_r.run)
            st_nxt.cap = st_r.count;                                                 // [R19]
         else
            st_nxt.cap = `TCM_CNT_RESET;
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_r      <= '0;
         st_r.trig <= TCM_WAIT;
         st_r.cmp  <= `TCM_CMP_RESET;
         st_r.dbuf <= `TCM_CMP_RESET;
      end
      else
         st_r <= st_nxt;
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign timer_irq      = st_r.irq;
   assign timer_running  = st_r.run;
   assign timer_mode_reg = st_r.mode;
   assign count_value    = st_r.count;
   assign compare_reg_a  = st_r.dbuf;                                                // [R18]
   assign capture_b_low  = st_r.cap[7:0];
   assign capture_b_high = st_r.cap[15:8];

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   sequence s_running2;
      st_r.run ##1 st_r.run;
   endsequence

   sequence s_ext_stop_edge;
      st_r.run && is_ext && st_r.trig == TCM_COUNT && st_r.mode.stop_en && opp_edge;
   endsequence

   property p_stopped_zero;
      !st_r.run |-> st_r.count == `TCM_CNT_RESET;
   endproperty
   a_stopped_zero: assert property (p_stopped_zero) else $error("count not zero while stopped"); // [R8]

   property p_match_irq;
      match |=> timer_irq && count_value == `TCM_CNT_RESET ##1 !timer_irq;
   endproperty
   a_match_irq: assert property (p_match_irq) else $error("match did not pulse irq and clear"); // [R5]

   property p_mode_locked;
      s_running2 |-> $stable(st_r.mode);
   endproperty
   a_mode_locked: assert property (p_mode_locked) else $error("mode changed while running"); // [R3]

   property p_ext_idle;
      st_r.run && is_ext && st_r.trig == TCM_WAIT |-> st_r.count == `TCM_CNT_RESET;
   endproperty
   a_ext_idle: assert property (p_ext_idle) else $error("counting before trigger edge"); // [R4]

   property p_event_inc;
      st_r.run && is_event && sel_edge && !match ##1 st_r.run |->
         st_r.count == $past(st_r.count) + 16'h0001;
   endproperty
   a_event_inc: assert property (p_event_inc) else $error("event edge not counted"); // [R10]

   property p_window_hold;
      st_r.run && is_win && !win_active ##1 st_r.run |-> $stable(st_r.count);
   endproperty
   a_window_hold: assert property (p_window_hold) else $error("counted outside window"); // [R13]

   property p_ext_stop;
      s_ext_stop_edge |=> st_r.trig == TCM_WAIT && st_r.count == `TCM_CNT_RESET;
   endproperty
   a_ext_stop: assert property (p_ext_stop) else $error("opposite edge did not stop"); // [R6]

   property p_ext_no_stop;
      st_r.run && is_ext && st_r.trig == TCM_COUNT && !st_r.mode.stop_en ##1 st_r.run
         |-> st_r.trig == TCM_COUNT;
   endproperty
   a_ext_no_stop: assert property (p_ext_no_stop) else $error("edge not ignored while counting"); // [R7]

   property p_commit;
      compare_a_high_wr |=> compare_reg_a == {$past(compare_wdata), $past(st_r.temp)};
   endproperty
   a_commit: assert property (p_commit) else $error("compare bytes not committed together"); // [R17]

   property p_dbuf_hold;
      st_r.run && double_buffer_enable && compare_a_high_wr && !match |=> $stable(st_r.cmp);
   endproperty
   a_dbuf_hold: assert property (p_dbuf_hold) else $error("buffered compare took effect early"); // [R18]

   property p_gate_off;
      !timer_clock_gate |=> !timer_running;
   endproperty
   a_gate_off: assert property (p_gate_off) else $error("timer ran with clock gated"); // [R20]

endmodule // tcm_timer
